// File: pwc_channel.sv
// Pulse width capture channel 0 with APB registers, flag logic and interrupts
//
// Design decision made here: the APB interface to the registers.
module pwc_channel
   import pwc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Capture pin, split into its three signals
   input wire logic capturePinIn,
   output logic capturePinOut,
   output logic capturePinOutEn_n,
   // DMA unit hook
   input wire logic dmaTransferStart,
   input wire logic dmaFlagClearEnable,
   // Interrupts
   output logic registerAIrq,
   output logic irq
);
   pwc_timing_if tim();

   // Registers
   logic [15:0] haltCtrlA;
   logic [RUN_BITS-1:0] runBits;
   logic [7:0] control;
   logic [7:0] ioControl;
   logic [7:0] intEnable;
   logic flagA;
   logic flagArmed;
   logic [15:0] counter;
   logic [15:0] generalA;
   logic [IRQ_BITS-1:0] irqStatus;
   logic [IRQ_BITS-1:0] irqMask;
   logic pinLevel;

   // Bus decode
   logic setupPhase;
   logic writeStrobe;
   logic mapped;
   logic [31:0] next_prdata;

   // Events
   logic compareMode;
   logic outputMode;
   logic matchEvent;
   logic captureEvent;
   logic clearEvent;
   logic dmaClear;
   logic wrStart;
   logic wrControl;
   logic wrIo;
   logic wrFlags;
   logic wrCounter;
   logic wrGeneralA;

   function automatic logic hit(input logic [31:0] addr, input logic [23:0] idx);
      return addr == pwcByteAddr(idx);
   endfunction

   // Carrier hookup
   assign tim.running = runBits[0];
   assign tim.halted = haltCtrlA[HALT_BIT];
   assign tim.prescaleSel = control[PSC_MSB:PSC_LSB];
   assign tim.edgeSel = control[EDGE_MSB:EDGE_LSB];
   assign tim.ioMode = ioControl[MODE_MSB:0];
   assign tim.pinIn = capturePinIn;

   pwc_prescaler #(
      .DIV_W(7)
   ) u_prescaler (
      .clk(clk),
      .reset_n(reset_n),
      .tim(tim.prescaler)
   );

   pwc_capture_edge u_capture (
      .clk(clk),
      .reset_n(reset_n),
      .tim(tim.detect)
   );

   // APB: zero wait states, read data latched in the setup cycle
   assign pready = 1'b1;
   assign setupPhase = psel && !penable;
   assign writeStrobe = psel && penable && pwrite;

   always_comb begin
      mapped = 1'b1;
      next_prdata = 32'h0000_0000;
      if (hit(paddr, IDX_HALT_CTRL_A)) begin
         next_prdata[15:0] = haltCtrlA;
      end else if (hit(paddr, IDX_START)) begin
         next_prdata[RUN_BITS-1:0] = runBits;
      end else if (hit(paddr, IDX_CONTROL)) begin
         next_prdata[7:0] = control;
      end else if (hit(paddr, IDX_IO_CONTROL)) begin
         next_prdata[7:0] = ioControl;
      end else if (hit(paddr, IDX_INT_ENABLE)) begin
         next_prdata[7:0] = intEnable;
      end else if (hit(paddr, IDX_EVENT_FLAGS)) begin
         next_prdata[FLAG_A_BIT] = flagA;
      end else if (hit(paddr, IDX_COUNTER)) begin
         next_prdata[15:0] = counter;
      end else if (hit(paddr, IDX_GENERAL_A)) begin
         next_prdata[15:0] = generalA;
      end else if (hit(paddr, IDX_IRQ_STATUS)) begin
         next_prdata[IRQ_BITS-1:0] = irqStatus;
      end else if (hit(paddr, IDX_IRQ_MASK)) begin
         next_prdata[IRQ_BITS-1:0] = irqMask;
      end else begin
         mapped = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (setupPhase) begin
         prdata <= pwrite ? 32'h0000_0000 : next_prdata;
         pslverr <= !mapped;
      end
   end

   assign wrStart = writeStrobe && hit(paddr, IDX_START);
   assign wrControl = writeStrobe && hit(paddr, IDX_CONTROL);
   assign wrIo = writeStrobe && hit(paddr, IDX_IO_CONTROL);
   assign wrFlags = writeStrobe && hit(paddr, IDX_EVENT_FLAGS);
   assign wrCounter = writeStrobe && hit(paddr, IDX_COUNTER);
   assign wrGeneralA = writeStrobe && hit(paddr, IDX_GENERAL_A);

   // Plain configuration registers
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         haltCtrlA <= HALT_RESET;
         runBits <= '0;
         control <= BYTE_RESET;
         ioControl <= BYTE_RESET;
         intEnable <= BYTE_RESET;
         irqMask <= '0;
      end else if (writeStrobe) begin
         if (hit(paddr, IDX_HALT_CTRL_A)) begin
            haltCtrlA <= pwdata[15:0];
         end
         if (wrStart) begin
            runBits <= pwdata[RUN_BITS-1:0];
         end
         if (wrControl) begin
            control <= pwdata[7:0];
         end
         if (wrIo) begin
            ioControl <= pwdata[7:0];
         end
         if (hit(paddr, IDX_INT_ENABLE)) begin
            intEnable <= pwdata[7:0];
         end
         if (hit(paddr, IDX_IRQ_MASK)) begin
            irqMask <= pwdata[IRQ_BITS-1:0];
         end
      end
   end

   // Register A events
   assign compareMode = !ioControl[MODE_CAPTURE_BIT];
   assign outputMode = compareMode && (ioControl[1:0] != ACT_NONE);
   assign matchEvent = compareMode && tim.countTick && (counter == generalA);
   assign captureEvent = tim.captureHit;
   assign clearEvent = (control[CLEAR_MSB:CLEAR_LSB] == CLEAR_ON_A)
      && (matchEvent || captureEvent);

   // Counter: software write, then clear, then count
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         counter <= COUNTER_RESET;
      end else if (wrCounter) begin
         counter <= pwdata[15:0];
      end else if (clearEvent) begin
         counter <= COUNTER_RESET;
      end else if (tim.countTick) begin
         counter <= counter + 16'h0001;
      end
   end

   // Register A takes the count before any clear
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         generalA <= 16'h0000;
      end else if (captureEvent) begin
         generalA <= counter;
      end else if (wrGeneralA) begin
         generalA <= pwdata[15:0];
      end
   end

   // Flag A: armed by a read of 1, cleared by a later write of 0
   assign dmaClear = dmaTransferStart && dmaFlagClearEnable && registerAIrq;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         flagArmed <= 1'b0;
      end else if (wrFlags) begin
         flagArmed <= 1'b0;
      end else if (setupPhase && !pwrite && hit(paddr, IDX_EVENT_FLAGS) && flagA) begin
         flagArmed <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         flagA <= 1'b0;
      end else if (matchEvent || captureEvent) begin
         flagA <= 1'b1;
      end else if (wrFlags && flagArmed && !pwdata[FLAG_A_BIT]) begin
         flagA <= 1'b0;
      end else if (dmaClear) begin
         flagA <= 1'b0;
      end
   end

   assign registerAIrq = flagA && intEnable[IRQ_EN_A_BIT];

   // Sticky event status, write one to clear, set wins
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         irqStatus <= '0;
      end else begin
         for (int i = 0; i < IRQ_BITS; i++) begin
            if ((i == IRQ_CAPTURE_BIT && captureEvent)
                  || (i == IRQ_COMPARE_BIT && matchEvent)) begin
               irqStatus[i] <= 1'b1;
            end else if (writeStrobe && hit(paddr, IDX_IRQ_STATUS) && pwdata[i]) begin
               irqStatus[i] <= 1'b0;
            end
         end
      end
   end

   assign irq = |(irqStatus & irqMask);

   // Pin level: initial level on a stopped write, compare action on match
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pinLevel <= 1'b0;
      end else if (wrIo && !runBits[0]) begin
         pinLevel <= pwdata[MODE_INIT_BIT];
      end else if (matchEvent && outputMode) begin
         if (ioControl[1:0] == ACT_LOW) begin
            pinLevel <= 1'b0;
         end else if (ioControl[1:0] == ACT_HIGH) begin
            pinLevel <= 1'b1;
         end else begin
            pinLevel <= !pinLevel;
         end
      end
   end

   // Stopping leaves pinLevel untouched
   assign capturePinOut = pinLevel;
   assign capturePinOutEn_n = !outputMode;

   a_run_bits_store: assert property (@(posedge clk) disable iff (!reset_n)
      wrStart |=> runBits == $past(pwdata[RUN_BITS-1:0]))
      else $error("run bits not taken from write");

   a_stop_keeps_pin: assert property (@(posedge clk) disable iff (!reset_n)
      $fell(runBits[0]) && !$past(wrIo) |-> $stable(capturePinOut))
      else $error("pin level changed on stop");

   a_init_level: assert property (@(posedge clk) disable iff (!reset_n)
      wrIo && !runBits[0] |=> capturePinOut == $past(pwdata[MODE_INIT_BIT]))
      else $error("initial level not driven");

   a_clear_on_a: assert property (@(posedge clk) disable iff (!reset_n)
      (control[CLEAR_MSB:CLEAR_LSB] == CLEAR_ON_A) && captureEvent && !wrCounter
      |=> counter == 16'h0000)
      else $error("counter not cleared on capture");

   a_div1_counts: assert property (@(posedge clk) disable iff (!reset_n)
      runBits[0] && !tim.halted && control[7:0] == 8'h00 && !wrCounter
      && !wrControl && !clearEvent
      |=> counter == $past(counter) + 16'h0001)
      else $error("divide by one does not count every cycle");

   a_compare_flag: assert property (@(posedge clk) disable iff (!reset_n)
      compareMode && tim.countTick && counter == generalA |=> flagA)
      else $error("compare match did not set flag");

   a_capture_copy: assert property (@(posedge clk) disable iff (!reset_n)
      captureEvent |=> generalA == $past(counter) && flagA)
      else $error("capture value or flag wrong");

   a_flag_write_one: assert property (@(posedge clk) disable iff (!reset_n)
      !flagA && !matchEvent && !captureEvent |=> !flagA)
      else $error("flag set without an event");

   a_flag_needs_read: assert property (@(posedge clk) disable iff (!reset_n)
      flagA && !flagArmed && !dmaClear |=> flagA)
      else $error("flag cleared without a read");

   a_dma_clear: assert property (@(posedge clk) disable iff (!reset_n)
      dmaClear && !matchEvent && !captureEvent |=> !flagA)
      else $error("DMA start did not clear flag");

   a_irq_gate: assert property (@(posedge clk) disable iff (!reset_n)
      !intEnable[IRQ_EN_A_BIT] |-> !registerAIrq)
      else $error("interrupt while disabled");

   a_halt_freeze: assert property (@(posedge clk) disable iff (!reset_n)
      haltCtrlA[HALT_BIT] && !wrCounter |=> $stable(counter))
      else $error("counter moved while halted");

   a_stop_no_count: assert property (@(posedge clk) disable iff (!reset_n)
      !runBits[0] && !wrCounter && !clearEvent |=> $stable(counter))
      else $error("counter moved while stopped");

   a_rise_capture: assert property (@(posedge clk) disable iff (!reset_n)
      ioControl[MODE_MSB:0] == MODE_CAPT_RISE && !haltCtrlA[HALT_BIT]
      && $rose(capturePinIn) |-> captureEvent)
      else $error("rising edge not captured");

   a_fall_capture: assert property (@(posedge clk) disable iff (!reset_n)
      ioControl[MODE_MSB:0] == MODE_CAPT_FALL && !haltCtrlA[HALT_BIT]
      && $fell(capturePinIn) |-> captureEvent)
      else $error("falling edge not captured");

   a_compare_toggle: assert property (@(posedge clk) disable iff (!reset_n)
      matchEvent && ioControl[1:0] == ACT_TOGGLE && !wrIo
      |=> capturePinOut != $past(capturePinOut))
      else $error("pin did not toggle on match");

   a_write_one_kept: assert property (@(posedge clk) disable iff (!reset_n)
      flagA && wrFlags && pwdata[FLAG_A_BIT] && !dmaClear |=> flagA)
      else $error("writing one cleared the flag");

   a_dma_needs_enable: assert property (@(posedge clk) disable iff (!reset_n)
      flagA && !wrFlags && !dmaFlagClearEnable |=> flagA)
      else $error("flag cleared without clear enable");

   a_halt_no_capture: assert property (@(posedge clk) disable iff (!reset_n)
      haltCtrlA[HALT_BIT] |-> !captureEvent)
      else $error("capture while halted");

   a_capture_then_clear: assert property (@(posedge clk) disable iff (!reset_n)
      captureEvent && control[CLEAR_MSB:CLEAR_LSB] == CLEAR_ON_A && !wrCounter
      |=> generalA == $past(counter) && counter == COUNTER_RESET)
      else $error("capture did not take count before clear");
endmodule

// File: pwc_pkg.sv
// Constants, register indices and field layout for the pulse width capture channel
// Contract
// - The start register holds one run bit per channel at bits 5 to 0; 1 runs, 0 stops.
// - Stopping a channel whose pin is an output stops the counter and keeps the pin level.
// - Writing the I/O control register while stopped drives the pin to the new initial level.
// - Control bits 7 to 5 pick the clear source; 001 clears on register A match or capture.
// - Control bits 4 and 3 pick the counting edge; 00 counts falling edges.
// - Control bits 2 to 0 pick the prescaler; 000 counts the peripheral clock divided by one.
// - I/O control bits 3 to 0 set register A mode; 1000 captures rising, 1001 falling edges.
// - Flag A at status bit 0 sets when the counter equals register A in compare mode.
// - In capture mode the counter is copied to register A on the capture edge and flag A set.
// - By software, flag A clears only by reading it as 1 and then writing 0; writing 1 does nothing.
// - Flag A also clears when the DMA unit is started by its interrupt with flag clear enabled.
// - The register A interrupt is high only while enable bit 0 is 1 and flag A is set.
// - Halt bit 0 of module halt control A freezes the timer unit until it is cleared.
// - The counter is 16 bits wide and starts at zero after reset.
package pwc_pkg;
   // Register indices; byte address is four times the index
   localparam logic [23:0] IDX_HALT_CTRL_A = 24'hFFFDC8;
   localparam logic [23:0] IDX_START = 24'hFFFFBC;
   localparam logic [23:0] IDX_CONTROL = 24'hFFFFC0;
   localparam logic [23:0] IDX_IO_CONTROL = 24'hFFFFC2;
   localparam logic [23:0] IDX_INT_ENABLE = 24'hFFFFC4;
   localparam logic [23:0] IDX_EVENT_FLAGS = 24'hFFFFC5;
   localparam logic [23:0] IDX_COUNTER = 24'hFFFFC6;
   localparam logic [23:0] IDX_GENERAL_A = 24'hFFFFC8;
   localparam logic [23:0] IDX_IRQ_STATUS = 24'hFFFFE0;
   localparam logic [23:0] IDX_IRQ_MASK = 24'hFFFFE1;

   // Field positions
   localparam int RUN_BITS = 6;
   localparam int HALT_BIT = 0;
   localparam int CLEAR_MSB = 7;
   localparam int CLEAR_LSB = 5;
   localparam int EDGE_MSB = 4;
   localparam int EDGE_LSB = 3;
   localparam int PSC_MSB = 2;
   localparam int PSC_LSB = 0;
   localparam int MODE_MSB = 3;
   localparam int MODE_CAPTURE_BIT = 3;
   localparam int MODE_INIT_BIT = 2;
   localparam int FLAG_A_BIT = 0;
   localparam int IRQ_EN_A_BIT = 0;
   localparam int IRQ_CAPTURE_BIT = 0;
   localparam int IRQ_COMPARE_BIT = 1;
   localparam int IRQ_BITS = 2;

   // Encodings
   localparam logic [2:0] CLEAR_ON_A = 3'h1;
   localparam logic [1:0] EDGE_FALL = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [2:0] PSC_DIV1 = 3'h0;
   localparam logic [3:0] MODE_CAPT_RISE = 4'h8;
   localparam logic [3:0] MODE_CAPT_FALL = 4'h9;
   localparam logic [1:0] ACT_NONE = 2'h0;
   localparam logic [1:0] ACT_LOW = 2'h1;
   localparam logic [1:0] ACT_HIGH = 2'h2;
   localparam logic [1:0] ACT_TOGGLE = 2'h3;

   // Reset values
   localparam logic [15:0] HALT_RESET = 16'h0000;
   localparam logic [15:0] COUNTER_RESET = 16'h0000;
   localparam logic [7:0] BYTE_RESET = 8'h00;

   function automatic logic [31:0] pwcByteAddr(input logic [23:0] idx);
      return {6'h00, idx, 2'h0};
   endfunction

   // Prescale divisor: 1, 4, 16, 64; reserved codes fall back to 1
   function automatic logic [6:0] pwcDivisor(input logic [2:0] sel);
      logic [6:0] d;
      d = 7'h01;
      if (sel < 3'h4) begin
         d = 7'(7'h01 << (2 * sel));
      end
      return d;
   endfunction
endpackage

// File: pwc_timing_if.sv
// Timing signals shared between the channel core, prescaler and capture detector
interface pwc_timing_if;
   logic running;
   logic halted;
   logic [2:0] prescaleSel;
   logic [1:0] edgeSel;
   logic [3:0] ioMode;
   logic pinIn;
   logic countTick;
   logic captureHit;
   modport core(output running, halted, prescaleSel, edgeSel, ioMode, pinIn,
      input countTick, captureHit);
   modport prescaler(input running, halted, prescaleSel, edgeSel, output countTick);
   modport detect(input halted, ioMode, pinIn, output captureHit);
endinterface

// File: pwc_prescaler.sv
// Prescaler and counting edge select giving a one-cycle count enable
module pwc_prescaler
   import pwc_pkg::*;
#(
   parameter int DIV_W = 7
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Timing carrier
   pwc_timing_if.prescaler tim
);
   if (DIV_W < 7) begin
      $error("pwc_prescaler: DIV_W too small for divide by 64");
   end

   logic [DIV_W-1:0] phase;
   logic [DIV_W-1:0] divisor;
   logic active;
   logic fallTick;
   logic riseTick;

   assign divisor = DIV_W'(pwcDivisor(tim.prescaleSel));
   assign active = tim.running && !tim.halted;
   // Divided clock falls at the end of its period and rises half way through
   assign fallTick = active && (phase == divisor - DIV_W'(1));
   assign riseTick = active && ((divisor == DIV_W'(1)) ? 1'b1 :
      (phase == (divisor >> 1) - DIV_W'(1)));

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         phase <= '0;
      end else if (!active || fallTick) begin
         phase <= '0;
      end else begin
         phase <= phase + DIV_W'(1);
      end
   end

   always_comb begin
      if (tim.edgeSel == EDGE_FALL) begin
         tim.countTick = fallTick;
      end else if (tim.edgeSel == EDGE_RISE) begin
         tim.countTick = riseTick;
      end else begin
         tim.countTick = fallTick || riseTick;
      end
   end
endmodule

// File: pwc_capture_edge.sv
// Edge detector on the capture pin for register A capture modes
module pwc_capture_edge
   import pwc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Timing carrier
   pwc_timing_if.detect tim
);
   logic prevPin;
   logic rise;
   logic fall;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         prevPin <= 1'b0;
      end else begin
         prevPin <= tim.pinIn;
      end
   end

   assign rise = tim.pinIn && !prevPin;
   assign fall = !tim.pinIn && prevPin;

   always_comb begin
      tim.captureHit = 1'b0;
      if (tim.halted) begin
         tim.captureHit = 1'b0;
      end else if (tim.ioMode == MODE_CAPT_RISE) begin
         tim.captureHit = rise;
      end else if (tim.ioMode == MODE_CAPT_FALL) begin
         tim.captureHit = fall;
      end else if (tim.ioMode[MODE_CAPTURE_BIT]) begin
         tim.captureHit = rise || fall;
      end
   end
endmodule

// File: pwc_pulse_src.sv
// Pulse source model that drives the capture pin from the far side
module pwc_pulse_src (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Command from the bench
   input wire logic trigger,
   input wire logic [15:0] width,
   // Pin side
   output logic pin,
   output logic busy
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] left;
   assign busy = (left != 16'h0000);
   // Pin idles low and goes high for exactly width cycles per trigger; a width of 0 leaves it high
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pin <= 1'b0;
         left <= 16'h0000;
      end else if (trigger && !busy) begin
         pin <= 1'b1;
         left <= width;
      end else if (left > 16'h0001) begin
         left <= left - 16'h0001;
      end else if (left == 16'h0001) begin
         pin <= 1'b0;
         left <= 16'h0000;
      end
   end
endmodule

// File: pulse_width_capture_channel_test.sv
// Self-checking bench for the pulse width capture channel
module pulse_width_capture_channel_test;
   import pwc_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, reset_n, psel, penable, pwrite, pready, pslverr;
   logic [31:0] paddr, pwdata, prdata;
   logic pinIn, pinOut, pinOutEn_n, dmaStart, dmaClrEn, registerAIrq, irq;
   logic trigger, srcPin, srcBusy;
   logic [15:0] width;
   logic [31:0] cnt1;
   int errorCnt, checkCount;
   logic [23:0] regs [8] = '{IDX_HALT_CTRL_A, IDX_START, IDX_CONTROL, IDX_IO_CONTROL,
      IDX_INT_ENABLE, IDX_EVENT_FLAGS, IDX_COUNTER, IDX_GENERAL_A};
   // Pin level seen by the channel: its own drive wins over the source
   assign pinIn = (pinOutEn_n === 1'b0) ? pinOut : srcPin;
   pwc_channel i_dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .capturePinIn(pinIn), .capturePinOut(pinOut),
      .capturePinOutEn_n(pinOutEn_n), .dmaTransferStart(dmaStart),
      .dmaFlagClearEnable(dmaClrEn), .registerAIrq(registerAIrq), .irq(irq));
   pwc_pulse_src i_src (.clk(clk), .reset_n(reset_n), .trigger(trigger), .width(width),
      .pin(srcPin), .busy(srcBusy));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic closeOut();
      $display("errors %0d checks %0d", errorCnt, checkCount);
      if (errorCnt == 0 && checkCount > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checkCount++;
      if (seen !== exp) begin
         errorCnt++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic hang(input string what);
      errorCnt++;
      $display("[FAIL] %0t timeout %s", $time, what);
      closeOut();
   endtask
   // Whole-word APB transfer; request held until pready is sampled
   task automatic apb(input logic w, input logic [23:0] idx, input logic [31:0] d,
      output logic [31:0] r, output logic err);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= pwcByteAddr(idx);
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) hang("apb");
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [23:0] idx, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, idx, d, r, e);
   endtask
   task automatic rd(input logic [23:0] idx, input logic [31:0] exp);
      logic [31:0] r;
      logic e;
      apb(1'b0, idx, 32'h0, r, e);
      chk(r, exp);
   endtask
   task automatic waitIrq();
      int n;
      n = 0;
      while (registerAIrq !== 1'b1 && n < 300) begin
         @(posedge clk);
         n++;
      end
      if (n >= 300) hang("irq");
   endtask
   task automatic pulse(input logic [15:0] w);
      int n;
      n = 0;
      @(posedge clk);
      width <= w;
      trigger <= 1'b1;
      @(posedge clk);
      trigger <= 1'b0;
      @(posedge clk);
      while (srcBusy === 1'b1 && n < 300) begin
         @(posedge clk);
         n++;
      end
      if (n >= 300) hang("pulse");
      repeat (3) @(posedge clk);
   endtask
   task automatic dma(input logic en);
      @(posedge clk);
      dmaClrEn <= en;
      dmaStart <= 1'b1;
      @(posedge clk);
      dmaStart <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   initial begin
      logic [31:0] r;
      logic e;
      errorCnt = 0;
      checkCount = 0;
      reset_n = 1'b0;
      {psel, penable, pwrite, trigger, dmaStart, dmaClrEn} = 6'h00;
      paddr = 32'h0;
      pwdata = 32'h0;
      width = 16'h0000;
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      foreach (regs[i]) rd(regs[i], 32'h0);
      apb(1'b0, 24'hFFFFF0, 32'h0, r, e);
      chk({31'h0, e}, 32'h1);
      chk(r, 32'h0);
      // Clear on A, falling count edge, divide by one, capture rising
      wr(IDX_CONTROL, 32'h20);
      wr(IDX_IO_CONTROL, 32'h08);
      wr(IDX_INT_ENABLE, 32'h01);
      wr(IDX_IRQ_MASK, 32'h01);
      wr(IDX_START, 32'h01);
      fork
         pulse(16'd40);
         begin
            waitIrq();
            rd(IDX_EVENT_FLAGS, 32'h1);
            wr(IDX_EVENT_FLAGS, 32'h0);
            wr(IDX_IO_CONTROL, 32'h09);
         end
      join
      chk({31'h0, registerAIrq}, 32'h1);
      rd(IDX_GENERAL_A, 32'd39);
      // Clearing needs a read first; writing one does nothing
      wr(IDX_EVENT_FLAGS, 32'h0);
      @(posedge clk);
      chk({31'h0, registerAIrq}, 32'h1);
      wr(IDX_EVENT_FLAGS, 32'h1);
      @(posedge clk);
      chk({31'h0, registerAIrq}, 32'h1);
      rd(IDX_EVENT_FLAGS, 32'h1);
      wr(IDX_EVENT_FLAGS, 32'h0);
      @(posedge clk);
      chk({31'h0, registerAIrq}, 32'h0);
      rd(IDX_IRQ_STATUS, 32'h1);
      chk({31'h0, irq}, 32'h1);
      wr(IDX_IRQ_STATUS, 32'h1);
      @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      // Enable off suppresses the request, flag still set
      wr(IDX_INT_ENABLE, 32'h00);
      pulse(16'd20);
      chk({31'h0, registerAIrq}, 32'h0);
      chk({31'h0, irq}, 32'h1);
      rd(IDX_EVENT_FLAGS, 32'h1);
      wr(IDX_INT_ENABLE, 32'h01);
      @(posedge clk);
      chk({31'h0, registerAIrq}, 32'h1);
      dma(1'b0);
      chk({31'h0, registerAIrq}, 32'h1);
      dma(1'b1);
      chk({31'h0, registerAIrq}, 32'h0);
      // Halted unit neither counts nor captures
      wr(IDX_HALT_CTRL_A, 32'h1);
      apb(1'b0, IDX_COUNTER, 32'h0, cnt1, e);
      pulse(16'd20);
      chk({31'h0, registerAIrq}, 32'h0);
      rd(IDX_COUNTER, cnt1);
      wr(IDX_HALT_CTRL_A, 32'h0);
      rd(IDX_EVENT_FLAGS, 32'h0);
      // Compare mode: initial level, toggle on match, level kept after stop
      wr(IDX_START, 32'h00);
      wr(IDX_CONTROL, 32'h00);
      wr(IDX_COUNTER, 32'h0);
      wr(IDX_GENERAL_A, 32'd10);
      wr(IDX_IRQ_STATUS, 32'h3);
      wr(IDX_IO_CONTROL, 32'h07);
      @(posedge clk);
      chk({31'h0, pinOut}, 32'h1);
      chk({31'h0, pinOutEn_n}, 32'h0);
      wr(IDX_IO_CONTROL, 32'h03);
      @(posedge clk);
      chk({31'h0, pinOut}, 32'h0);
      wr(IDX_START, 32'h01);
      waitIrq();
      @(posedge clk);
      chk({31'h0, pinOut}, 32'h1);
      wr(IDX_START, 32'h00);
      repeat (3) @(posedge clk);
      chk({31'h0, pinOut}, 32'h1);
      rd(IDX_EVENT_FLAGS, 32'h1);
      rd(IDX_IRQ_STATUS, 32'h2);
      apb(1'b0, IDX_COUNTER, 32'h0, cnt1, e);
      rd(IDX_COUNTER, cnt1);
      // Divide by four: falling edge ends each period, rising edge is half way
      wr(IDX_CONTROL, 32'h01);
      wr(IDX_COUNTER, 32'h0);
      wr(IDX_START, 32'h01);
      repeat (35) @(posedge clk);
      wr(IDX_START, 32'h00);
      rd(IDX_COUNTER, 32'h9);
      wr(IDX_CONTROL, 32'h09);
      wr(IDX_COUNTER, 32'h0);
      wr(IDX_START, 32'h01);
      repeat (35) @(posedge clk);
      wr(IDX_START, 32'h00);
      rd(IDX_COUNTER, 32'hA);
      closeOut();
   end
endmodule
